// *** rtl/phy_diag_map.vh ***
// How it works
// - Partner pause ability shown read-only, bit 10
// - Partner speed/duplex abilities in bits 8..5
// - Writing start bit runs test; self-clears
// - Outcome code in bits 14:13, resets normal
// - Bit 12 flags short under ten meters
// - Nine-bit fault distance count, bits 8:0
// - Bit 5 shows reversed receive polarity
// - Bit 4 shows crossover: one straight
// - Bit 3 forces link pass
// - Bit 2 low enables power saving
// - Bit 1 loops receive pair to transmit
// - Auto-negotiation complete flag read-only
`ifndef PHY_DIAG_MAP_VH
`define PHY_DIAG_MAP_VH
`define ADDR_PARTNER_ABILITY 5'h05
`define ADDR_BASIC_STATUS    5'h01
`define ADDR_CABLE_DIAG      5'h1d
`define ADDR_SPECIAL_CTRL    5'h1f
`define BIT_LP_PAUSE         10
`define BIT_LP_100FD         8
`define BIT_LP_100HD         7
`define BIT_LP_10FD          6
`define BIT_LP_10HD          5
`define BIT_AN_COMPLETE      5
`define BIT_DIAG_START       15
`define BIT_DIAG_RES_HI      14
`define BIT_DIAG_RES_LO      13
`define BIT_NEAR_SHORT       12
`define BIT_POL_REVERSED     5
`define BIT_MDI_STRAIGHT     4
`define BIT_FORCE_LINK       3
`define BIT_PWRSAVE_OFF      2
`define BIT_REMOTE_LOOP      1
`define RST_DIAG_RESULT      2'h0
`define RST_FAULT_COUNT      9'h000
`define RST_FORCE_LINK       1'h0
`define RST_PWRSAVE_OFF      1'h1
`define RST_REMOTE_LOOP      1'h0
`endif

// *** rtl/phy_mgmt_diag_registers.v ***
`timescale 1ns/1ps
`include "phy_diag_map.vh"
module phy_mgmt_diag_registers (
  input  wire        sys_clk,          // 20 MHz clock
  input  wire        rst,              // Sync reset, active high
  input  wire        clk_en,           // Freezes all state when low
  input  wire [4:0]  reg_addr,         // Management register address
  input  wire        reg_wr,           // Write strobe
  input  wire        reg_rd,           // Read strobe
  input  wire [15:0] reg_wdata,        // Write data
  output reg  [15:0] reg_rdata,        // Read data, valid cycle after reg_rd
  input  wire [4:0]  lp_ability,       // Partner pause,100fd,100hd,10fd,10hd
  input  wire        an_complete,      // Auto-negotiation done
  input  wire        pol_reversed,     // Receive polarity reversed
  input  wire        mdi_straight,     // Resolved crossover, 1 = MDI
  input  wire        diag_done,        // Test engine finished pulse
  input  wire [1:0]  diag_result,      // Engine outcome code
  input  wire        diag_near_short,  // Engine: short under 10 m
  input  wire [8:0]  diag_distance,    // Engine: fault distance count
  output reg         diag_start,       // Test running, to engine
  output reg         force_link_pass,  // Force link pass
  output reg         pwrsave_off,      // 1 disables power saving
  output reg         remote_loop       // Loop receive pair to transmit pair
);

  reg [4:0] lp_reg;
  reg [1:0] result_reg;
  reg       near_short_reg;
  reg [8:0] distance_reg;
  reg       an_reg;
  reg       pol_reg;
  reg       mdi_reg;
  reg [15:0] rdata_next;

  // Read mux; unlisted addresses and reserved bits read zero
  always @* begin
    rdata_next = 16'h0000;
    case (reg_addr)
      `ADDR_PARTNER_ABILITY: begin
        rdata_next[`BIT_LP_PAUSE] = lp_reg[4];
        rdata_next[`BIT_LP_100FD:`BIT_LP_10HD] = lp_reg[3:0];
      end
      `ADDR_BASIC_STATUS: begin
        rdata_next[`BIT_AN_COMPLETE] = an_reg;
      end
      `ADDR_CABLE_DIAG: begin
        rdata_next[`BIT_DIAG_START] = diag_start;
        rdata_next[`BIT_DIAG_RES_HI:`BIT_DIAG_RES_LO] = result_reg;
        rdata_next[`BIT_NEAR_SHORT] = near_short_reg;
        rdata_next[8:0] = distance_reg;
      end
      `ADDR_SPECIAL_CTRL: begin
        rdata_next[`BIT_POL_REVERSED] = pol_reg;
        rdata_next[`BIT_MDI_STRAIGHT] = mdi_reg;
        rdata_next[`BIT_FORCE_LINK]   = force_link_pass;
        rdata_next[`BIT_PWRSAVE_OFF]  = pwrsave_off;
        rdata_next[`BIT_REMOTE_LOOP]  = remote_loop;
      end
      default: rdata_next = 16'h0000;
    endcase
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata       <= 16'h0000;
      lp_reg          <= 5'h00;
      an_reg          <= 1'h0;
      pol_reg         <= 1'h0;
      mdi_reg         <= 1'h0;
      result_reg      <= `RST_DIAG_RESULT;
      near_short_reg  <= 1'h0;
      distance_reg    <= `RST_FAULT_COUNT;
      diag_start      <= 1'h0;
      force_link_pass <= `RST_FORCE_LINK;
      pwrsave_off     <= `RST_PWRSAVE_OFF;
      remote_loop     <= `RST_REMOTE_LOOP;
    end else if (clk_en) begin
      lp_reg  <= lp_ability;
      an_reg  <= an_complete;
      pol_reg <= pol_reversed;
      mdi_reg <= mdi_straight;
      if (reg_rd)
        reg_rdata <= rdata_next;
      // Results latched only on completion so they stay stable for the station
      if (diag_start && diag_done) begin
        diag_start     <= 1'h0;
        result_reg     <= diag_result;
        near_short_reg <= diag_near_short;
        distance_reg   <= diag_distance;
      end
      if (reg_wr && reg_addr == `ADDR_CABLE_DIAG && reg_wdata[`BIT_DIAG_START])
        diag_start <= 1'h1;
      if (reg_wr && reg_addr == `ADDR_SPECIAL_CTRL) begin
        force_link_pass <= reg_wdata[`BIT_FORCE_LINK];
        pwrsave_off     <= reg_wdata[`BIT_PWRSAVE_OFF];
        remote_loop     <= reg_wdata[`BIT_REMOTE_LOOP];
      end
    end
  end

endmodule // phy_mgmt_diag_registers

// *** bench/diag_regs_monitor.sv ***
`timescale 1ns/1ps
module diag_regs_monitor (
  input wire        sys_clk, rst, clk_en, reg_wr, reg_rd, diag_done, diag_start,
  input wire        force_link_pass, pwrsave_off, remote_loop,
  input wire [4:0]  reg_addr,
  input wire [15:0] reg_wdata, reg_rdata
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Strobes only count on enabled edges
  wire go = clk_en && reg_wr && reg_addr == 5'h1d && reg_wdata[15];
  wire sw = clk_en && reg_wr && reg_addr == 5'h1f;
  a_start_set: assert property (go |=> diag_start) else $error("start lost");
  a_start_clear: assert property (clk_en && diag_start && diag_done && !go |=> !diag_start) else $error("no clear");
  a_freeze_hold: assert property (!clk_en |=> $stable({diag_start, force_link_pass, pwrsave_off, remote_loop, reg_rdata})) else $error("freeze");
  a_start_hold: assert property (diag_start && !diag_done |=> diag_start) else $error("early clear");
  a_force_write: assert property (sw |=> force_link_pass == $past(reg_wdata[3])) else $error("force");
  a_pwrsave_write: assert property (sw |=> pwrsave_off == $past(reg_wdata[2])) else $error("pwrsave");
  a_loop_write: assert property (sw |=> remote_loop == $past(reg_wdata[1])) else $error("loop");
  a_ctrl_readback: assert property (clk_en && reg_rd && reg_addr == 5'h1f && !reg_wr |=> reg_rdata[15:6] == 10'h0
    && reg_rdata[3:1] == {force_link_pass, pwrsave_off, remote_loop}) else $error("readback");
  a_unmapped_zero: assert property (clk_en && reg_rd && !(reg_addr inside {5'h01, 5'h05, 5'h1d, 5'h1f})
    |=> reg_rdata == 16'h0000) else $error("unmapped");
endmodule // diag_regs_monitor

// *** bench/cable_test_engine.sv ***
`timescale 1ns/1ps
module cable_test_engine (
  input wire        sys_clk, diag_start,
  input wire [3:0]  lag,     // Cycles until the test ends
  input wire [11:0] outcome, // {code, near short, distance}
  output reg        diag_done = 1'b0,
  output wire [1:0] diag_result, output wire diag_near_short, output wire [8:0] diag_distance);
  reg [3:0] cnt_reg = 4'h0;
  // Inverted outside the pulse so a stale capture is caught
  assign {diag_result, diag_near_short, diag_distance} = diag_done ? outcome : ~outcome;
  always @(posedge sys_clk) begin
    diag_done <= diag_start && !diag_done && cnt_reg == lag;
    cnt_reg <= (diag_start && !diag_done) ? cnt_reg + 4'h1 : 4'h0;
  end
endmodule // cable_test_engine

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  reg sys_clk = 0, rst = 1, clk_en = 1, reg_wr = 0, reg_rd = 0;
  reg an_complete = 0, pol_reversed = 0, mdi_straight = 0;
  reg [4:0] reg_addr = 0, lp_ability = 0;
  reg [15:0] reg_wdata = 0, d;
  reg [3:0] lag = 0;
  reg [11:0] outcome = 0;
  wire [15:0] reg_rdata;
  wire diag_done, diag_near_short, diag_start, force_link_pass, pwrsave_off, remote_loop;
  wire [1:0] diag_result;
  wire [8:0] diag_distance;
  integer bad_count = 0, samples_checked = 0, i, n;
  phy_mgmt_diag_registers dut (.*);
  cable_test_engine engine (.*);
  always #25 sys_clk = ~sys_clk;
  task test_done;
    if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input [15:0] s, e);
    samples_checked++;
    if (s !== e) begin bad_count++; $display("BAD %0t %h %h", $time, s, e); end
  endtask
  task acc(input w, input [4:0] a, input [15:0] v);
    @(negedge sys_clk) {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, v};
    @(negedge sys_clk) {reg_wr, reg_rd} = 2'h0;
  endtask
  function [15:0] sc_exp(input [15:0] w);
    sc_exp = {10'h0, pol_reversed, mdi_straight, w[3:1], 1'b0};
  endfunction
  initial begin #200000 bad_count++; test_done; end
  initial begin
    n = $urandom(32'hc1974b0e);
    repeat (8) @(negedge sys_clk);
    rst = 0;
    acc(0, 5'h1f, 0); chk(reg_rdata, 16'h0004);
    acc(0, 5'h1d, 0); chk(reg_rdata, 16'h0000);
    for (i = 0; i < 12; i++) begin
      d = $urandom;
      {an_complete, pol_reversed, mdi_straight, lp_ability} = $urandom;
      acc(1, 5'h1f, d); acc(0, 5'h1f, 0); chk(reg_rdata, sc_exp(d));
      chk({force_link_pass, pwrsave_off, remote_loop}, d[3:1]);
      // A write while frozen must leave the controls alone
      clk_en = 0; acc(1, 5'h1f, ~d); clk_en = 1;
      chk({force_link_pass, pwrsave_off, remote_loop}, d[3:1]);
      acc(0, 5'h05, 0); chk(reg_rdata, {5'h0, lp_ability[4], 1'b0, lp_ability[3:0], 5'h0});
      acc(0, 5'h01, 0); chk(reg_rdata[5], an_complete);
      lag = $urandom; outcome = $urandom; outcome[11:10] = i[1:0];
      acc(1, 5'h1d, $urandom | 16'h8000);
      n = 0; d = 16'h8000;
      while (d[15] && n < 40) begin acc(0, 5'h1d, 0); d = reg_rdata; n++; end
      chk(d, {1'b0, outcome[11:9], 3'h0, outcome[8:0]});
      acc(0, 5'h1e, 0); chk(reg_rdata, 16'h0000);
    end
    test_done;
  end
endmodule // tb_top
bind phy_mgmt_diag_registers diag_regs_monitor mon (.*);
